/* hw/scu_regbank.sv */
// system configuration register bank behind an AHB-Lite slave port
// Notes on behaviour
// R1 - software holds each peripheral in reset or releases it through the peripheral reset control register.
// R2 - eight pin interrupt route registers each pick the digital pin feeding one pin interrupt channel.
// R3 - registers sit on word addresses and decoding ignores the two lowest address bits.
// R4 - reset values are the contents seen once boot code has run.
// R5 - software should not write offsets that hold no named register.
// R6 - pin levels are caught once after power-on reset into a read-only capture register.
// R7 - the interrupt delay register is writable and resets to sixteen.
// R8 - seven glitch filter clock divider registers exist and all reset to zero.
// R9 - deep-sleep, wake-up and run power configs reset to 0xFFFF, 0xEDF0 and 0xEDF0.
// R10 - the pin wake enable register resets to zero so no pin wakes the chip.
// R11 - the reset cause register is readable and writable and resets to zero.
// R12 - main clock select and its update enable are separate registers resetting to zero.
// R13 - baud fraction divider and multiplier registers reset to zero.
// R14 - a zero in a peripheral reset bit holds that peripheral in reset, a one releases it.
// R15 - reads of unassigned offsets return zero and writes to them do nothing.
`timescale 1ns/100ps
`default_nettype none

module scu_regbank #(
   // arbitrary value, not tied to any real part
   parameter logic [31:0] PART_ID = 32'h5C0F_0001
) (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic HREADYOUT,
   output logic [31:0] HRDATA,
   output logic HRESP,
   input wire logic PLL_LOCKED,
   input wire logic [scu_pkg::NCAUSE-1:0] RESET_CAUSE,
   input wire logic [31:0] PIN_LEVELS,
   output scu_pkg::scu_cfg_t CFG
);
   import scu_pkg::*;

   // ---------------------------------------------------------------
   // reset release
   // ---------------------------------------------------------------
   logic [1:0] rst_sync_q;
   logic rst_n;

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_q[1];

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   // returns {hit, index}; only bits 11:2 take part
   function automatic logic [IDX_W:0] decode(input logic [31:0] a);
      logic [IDX_W:0] r;
      r = '0;
      for (int i = 0; i < NREG; i++) begin
         if (a[11:2] == ROFF[i][11:2]) begin // [R3]
            r = {1'b1, IDX_W'(i)};
         end
      end
      return r;
   endfunction

   function automatic logic is_ro(input logic [IDX_W-1:0] i);
      return (i == RG_PLL_STATUS) || (i == RG_POWERON_PIN_CAPTURE) ||
             (i == RG_PART_IDENTIFIER);
   endfunction

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   scu_state_t q;
   scu_state_t d;
   logic addr_phase;
   logic [IDX_W:0] dec;

   assign addr_phase = HSEL && HREADY && HTRANS[1];
   assign dec = decode(HADDR);

   always_comb begin
      d = q;
      d.regs[RG_PLL_STATUS] = {31'h0, PLL_LOCKED};
      d.regs[RG_PART_IDENTIFIER] = PART_ID;
      // pins are caught on the first edge after reset release only
      if (!q.cap_done) begin
         d.regs[RG_POWERON_PIN_CAPTURE] = PIN_LEVELS; // [R6]
         d.cap_done = 1'b1;
      end
      // data phase of a write; misses and read-only targets drop it
      if (q.wr_pend && q.wr_hit && !is_ro(q.wr_idx)) begin // [R15]
         if (q.wr_idx == RG_RESET_CAUSE_STATUS) begin
            d.regs[RG_RESET_CAUSE_STATUS] =
               q.regs[RG_RESET_CAUSE_STATUS] & ~HWDATA; // [R11]
         end else begin
            d.regs[q.wr_idx] = HWDATA; // [R1] [R2] [R7] [R12]
         end
      end
      // a new cause is applied after the clear so it is never lost
      d.regs[RG_RESET_CAUSE_STATUS][NCAUSE-1:0] =
         d.regs[RG_RESET_CAUSE_STATUS][NCAUSE-1:0] | RESET_CAUSE; // [R11]
      d.wr_pend = 1'b0;
      if (addr_phase) begin
         d.wr_pend = HWRITE;
         d.wr_hit = dec[IDX_W];
         d.wr_idx = dec[IDX_W-1:0];
         if (!HWRITE) begin
            // read sees a write landing in this same cycle
            if (dec[IDX_W]) begin
               d.rdata = d.regs[dec[IDX_W-1:0]];
            end else begin
               d.rdata = 32'h0000_0000; // [R15]
            end
         end
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         for (int i = 0; i < NREG; i++) begin
            q.regs[i] <= RST_ZERO; // [R8] [R10] [R12] [R13]
         end
         q.regs[RG_MEMORY_REMAP] <= RST_MEMORY_REMAP; // [R4]
         q.regs[RG_PERIPHERAL_RESET_CONTROL] <= RST_PERIPHERAL_RESET;
         q.regs[RG_WDOG_OSC_CONTROL] <= RST_WDOG_OSC;
         q.regs[RG_SYSTEM_CLOCK_DIVIDER] <= RST_SYSTEM_CLOCK_DIV;
         q.regs[RG_SYSTEM_CLOCK_GATES] <= RST_SYSTEM_CLOCK_GATES;
         q.regs[RG_IRQ_DELAY_CONTROL] <= RST_IRQ_DELAY; // [R7]
         q.regs[RG_DEEPSLEEP_POWER_CONFIG] <= RST_DEEPSLEEP_POWER; // [R9]
         q.regs[RG_WAKEUP_POWER_CONFIG] <= RST_WAKEUP_POWER;
         q.regs[RG_RUN_POWER_CONFIG] <= RST_RUN_POWER;
      end else begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------
   // bus answers
   // ---------------------------------------------------------------
   // zero wait states: every transfer finishes in its first data cycle
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign HRDATA = q.rdata;

   // ---------------------------------------------------------------
   // configuration outputs
   // ---------------------------------------------------------------
   always_comb begin
      CFG = '0;
      CFG.mem_map = q.regs[RG_MEMORY_REMAP][1:0];
      // high bit releases the peripheral, so reset value lets all run
      CFG.periph_rst_n =
         q.regs[RG_PERIPHERAL_RESET_CONTROL][NPERIPH-1:0]; // [R14]
      CFG.main_clk_sel = q.regs[RG_MAIN_CLOCK_SELECT][1:0];
      CFG.main_clk_upd = q.regs[RG_MAIN_CLOCK_UPDATE][0];
      CFG.baud_div = q.regs[RG_BAUD_FRACTION_DIVIDER][7:0]; // [R13]
      CFG.baud_mul = q.regs[RG_BAUD_FRACTION_MULTIPLIER][7:0];
      for (int k = 0; k < NGLITCH; k++) begin
         CFG.glitch_div[k] =
            q.regs[int'(RG_GLITCH_CLOCK_DIV_0) - k][7:0]; // [R8]
      end
      CFG.irq_delay = q.regs[RG_IRQ_DELAY_CONTROL][7:0];
      for (int k = 0; k < NROUTE; k++) begin
         CFG.pin_route[k] =
            q.regs[int'(RG_PIN_IRQ_ROUTE_0) + k][7:0]; // [R2]
      end
      CFG.pin_wake_en = q.regs[RG_PIN_WAKE_ENABLE]; // [R10]
      CFG.sleep_pd = q.regs[RG_DEEPSLEEP_POWER_CONFIG][15:0]; // [R9]
      CFG.wake_pd = q.regs[RG_WAKEUP_POWER_CONFIG][15:0];
      CFG.run_pd = q.regs[RG_RUN_POWER_CONFIG][15:0];
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!rst_n);

   sequence s_wr(logic [11:0] o);
      addr_phase && HWRITE && (HADDR[11:2] == o[11:2]);
   endsequence

   sequence s_rd(logic [11:0] o);
      addr_phase && !HWRITE && (HADDR[11:2] == o[11:2]);
   endsequence

   property p_lands(logic [11:0] o, int i);
      s_wr(o) ##1 1'b1 |=> q.regs[i] == $past(HWDATA);
   endproperty

   a_prc_write: assert property ( // [R1]
      s_wr(ROFF[RG_PERIPHERAL_RESET_CONTROL]) ##1 1'b1 |=>
         CFG.periph_rst_n == $past(HWDATA[NPERIPH-1:0]))
      else $error("peripheral reset bits did not follow the write");

   a_route_write: assert property ( // [R2]
      s_wr(ROFF[RG_PIN_IRQ_ROUTE_7]) ##1 1'b1 |=>
         CFG.pin_route[7] == $past(HWDATA[7:0]))
      else $error("pin route 7 did not follow the write");

   a_read_align: assert property ( // [R3]
      s_rd(ROFF[RG_PERIPHERAL_RESET_CONTROL]) |=>
         HRDATA == q.regs[RG_PERIPHERAL_RESET_CONTROL])
      else $error("read data does not match the register");

   a_reset_values: assert property ( // [R4] [R7] [R9]
      $rose(rst_sync_q[1]) |->
         (CFG.irq_delay == 8'h10) && (CFG.sleep_pd == 16'hFFFF) &&
         (CFG.run_pd == 16'hEDF0) && (CFG.periph_rst_n == 13'h1FFF))
      else $error("register holds a wrong value after reset");

   a_capture_hold: assert property ( // [R6]
      q.cap_done |=> $stable(q.regs[RG_POWERON_PIN_CAPTURE]))
      else $error("pin capture changed after it was taken");

   a_delay_write: assert property ( // [R7]
      p_lands(ROFF[RG_IRQ_DELAY_CONTROL], RG_IRQ_DELAY_CONTROL))
      else $error("interrupt delay write was lost");

   a_glitch_write: assert property ( // [R8]
      s_wr(ROFF[RG_GLITCH_CLOCK_DIV_0]) ##1 1'b1 |=>
         CFG.glitch_div[0] == $past(HWDATA[7:0]))
      else $error("glitch divider 0 did not follow the write");

   a_wake_write: assert property ( // [R10]
      p_lands(ROFF[RG_PIN_WAKE_ENABLE], RG_PIN_WAKE_ENABLE))
      else $error("pin wake enable write was lost");

   a_cause_sets: assert property ( // [R11]
      (RESET_CAUSE != '0) |=>
         ((q.regs[RG_RESET_CAUSE_STATUS][NCAUSE-1:0] &
           $past(RESET_CAUSE)) == $past(RESET_CAUSE)))
      else $error("reset cause event was lost");

   a_clock_update: assert property ( // [R12]
      s_wr(ROFF[RG_MAIN_CLOCK_UPDATE]) ##1 1'b1 |=>
         CFG.main_clk_upd == $past(HWDATA[0]))
      else $error("main clock update bit did not follow the write");

   a_baud_write: assert property ( // [R13]
      p_lands(ROFF[RG_BAUD_FRACTION_MULTIPLIER],
              RG_BAUD_FRACTION_MULTIPLIER))
      else $error("baud multiplier write was lost");

   a_unmapped_zero: assert property ( // [R15]
      addr_phase && !HWRITE && !dec[IDX_W] |=> HRDATA == 32'h0)
      else $error("unassigned offset did not read as zero");

   a_unmapped_nowrite: assert property ( // [R15] [R5]
      addr_phase && HWRITE && !dec[IDX_W] ##1 1'b1 |=>
         $stable(q.regs[RG_PERIPHERAL_RESET_CONTROL]))
      else $error("write to unassigned offset changed a register");

   a_remap_write: assert property ( // [R3]
      p_lands(ROFF[RG_MEMORY_REMAP], RG_MEMORY_REMAP))
      else $error("memory remap write was lost");

   a_prc_lands: assert property ( // [R1]
      p_lands(ROFF[RG_PERIPHERAL_RESET_CONTROL], RG_PERIPHERAL_RESET_CONTROL))
      else $error("peripheral reset write was lost");

   a_pll_write: assert property ( // [R3]
      p_lands(ROFF[RG_PLL_CONTROL], RG_PLL_CONTROL))
      else $error("pll control write was lost");

   a_xosc_write: assert property ( // [R3]
      p_lands(ROFF[RG_CRYSTAL_OSC_CONTROL], RG_CRYSTAL_OSC_CONTROL))
      else $error("crystal control write was lost");

   a_wdosc_write: assert property ( // [R3]
      p_lands(ROFF[RG_WDOG_OSC_CONTROL], RG_WDOG_OSC_CONTROL))
      else $error("watchdog osc write was lost");

   a_pllsel_write: assert property ( // [R3]
      p_lands(ROFF[RG_PLL_SOURCE_SELECT], RG_PLL_SOURCE_SELECT))
      else $error("pll source select write was lost");

   a_pllupd_write: assert property ( // [R3]
      p_lands(ROFF[RG_PLL_SOURCE_UPDATE], RG_PLL_SOURCE_UPDATE))
      else $error("pll source update write was lost");

   a_mainsel_write: assert property ( // [R12]
      p_lands(ROFF[RG_MAIN_CLOCK_SELECT], RG_MAIN_CLOCK_SELECT))
      else $error("main clock select write was lost");

   a_mainupd_write: assert property ( // [R12]
      p_lands(ROFF[RG_MAIN_CLOCK_UPDATE], RG_MAIN_CLOCK_UPDATE))
      else $error("main clock update write was lost");

   a_sysdiv_write: assert property ( // [R3]
      p_lands(ROFF[RG_SYSTEM_CLOCK_DIVIDER], RG_SYSTEM_CLOCK_DIVIDER))
      else $error("system clock divider write was lost");

   a_gates_write: assert property ( // [R3]
      p_lands(ROFF[RG_SYSTEM_CLOCK_GATES], RG_SYSTEM_CLOCK_GATES))
      else $error("clock gate write was lost");

   a_serdiv_write: assert property ( // [R3]
      p_lands(ROFF[RG_SERIAL_CLOCK_DIVIDER], RG_SERIAL_CLOCK_DIVIDER))
      else $error("serial clock divider write was lost");

   a_outsel_write: assert property ( // [R3]
      p_lands(ROFF[RG_CLOCK_OUTPUT_SELECT], RG_CLOCK_OUTPUT_SELECT))
      else $error("clock output select write was lost");

   a_outupd_write: assert property ( // [R3]
      p_lands(ROFF[RG_CLOCK_OUTPUT_UPDATE], RG_CLOCK_OUTPUT_UPDATE))
      else $error("clock output update write was lost");

   a_outdiv_write: assert property ( // [R3]
      p_lands(ROFF[RG_CLOCK_OUTPUT_DIVIDER], RG_CLOCK_OUTPUT_DIVIDER))
      else $error("clock output divider write was lost");

   a_bauddiv_write: assert property ( // [R13]
      p_lands(ROFF[RG_BAUD_FRACTION_DIVIDER], RG_BAUD_FRACTION_DIVIDER))
      else $error("baud divider write was lost");

   a_trace_write: assert property ( // [R3]
      p_lands(ROFF[RG_TRACE_BUFFER_COMMAND], RG_TRACE_BUFFER_COMMAND))
      else $error("trace command write was lost");

   a_glitch6_write: assert property ( // [R8]
      p_lands(ROFF[RG_GLITCH_CLOCK_DIV_6], RG_GLITCH_CLOCK_DIV_6))
      else $error("glitch divider 6 write was lost");

   a_bod_write: assert property ( // [R3]
      p_lands(ROFF[RG_BROWNOUT_CONTROL], RG_BROWNOUT_CONTROL))
      else $error("brownout control write was lost");

   a_tick_write: assert property ( // [R3]
      p_lands(ROFF[RG_TICK_CALIBRATION], RG_TICK_CALIBRATION))
      else $error("tick calibration write was lost");

   a_nmi_write: assert property ( // [R3]
      p_lands(ROFF[RG_NONMASKABLE_SOURCE], RG_NONMASKABLE_SOURCE))
      else $error("nonmaskable source write was lost");

   a_route0_write: assert property ( // [R2]
      p_lands(ROFF[RG_PIN_IRQ_ROUTE_0], RG_PIN_IRQ_ROUTE_0))
      else $error("pin route 0 write was lost");

   a_irqwake_write: assert property ( // [R3]
      p_lands(ROFF[RG_IRQ_WAKE_ENABLE], RG_IRQ_WAKE_ENABLE))
      else $error("irq wake enable write was lost");

   a_sleep_write: assert property ( // [R9]
      p_lands(ROFF[RG_DEEPSLEEP_POWER_CONFIG], RG_DEEPSLEEP_POWER_CONFIG))
      else $error("deep-sleep config write was lost");

   a_wakepd_write: assert property ( // [R9]
      p_lands(ROFF[RG_WAKEUP_POWER_CONFIG], RG_WAKEUP_POWER_CONFIG))
      else $error("wake-up config write was lost");

   a_runpd_write: assert property ( // [R9]
      p_lands(ROFF[RG_RUN_POWER_CONFIG], RG_RUN_POWER_CONFIG))
      else $error("run config write was lost");

   a_pll_live: assert property ( // [R3]
      s_rd(ROFF[RG_PLL_STATUS]) |=> HRDATA == {31'h0, $past(PLL_LOCKED)})
      else $error("pll status read is not live");

   a_id_read: assert property ( // [R3]
      s_rd(ROFF[RG_PART_IDENTIFIER]) |=> HRDATA == PART_ID)
      else $error("part identifier read is wrong");

   a_capture_ro: assert property ( // [R6]
      s_wr(ROFF[RG_POWERON_PIN_CAPTURE]) ##1 1'b1 |=>
         $stable(q.regs[RG_POWERON_PIN_CAPTURE]))
      else $error("write reached the pin capture");

endmodule // scu_regbank

`default_nettype wire

/* hw/scu_pkg.sv */
// package: register map, reset values and carrier types of the config bank
package scu_pkg;

   // ---------------------------------------------------------------
   // register indices, in the order of the offset table below
   // ---------------------------------------------------------------
   localparam int NREG = 46;
   localparam int IDX_W = 6;

   typedef enum logic [IDX_W-1:0] {
      RG_MEMORY_REMAP, RG_PERIPHERAL_RESET_CONTROL, RG_PLL_CONTROL,
      RG_PLL_STATUS, RG_CRYSTAL_OSC_CONTROL, RG_WDOG_OSC_CONTROL,
      RG_RESET_CAUSE_STATUS, RG_PLL_SOURCE_SELECT, RG_PLL_SOURCE_UPDATE,
      RG_MAIN_CLOCK_SELECT, RG_MAIN_CLOCK_UPDATE, RG_SYSTEM_CLOCK_DIVIDER,
      RG_SYSTEM_CLOCK_GATES, RG_SERIAL_CLOCK_DIVIDER,
      RG_CLOCK_OUTPUT_SELECT, RG_CLOCK_OUTPUT_UPDATE,
      RG_CLOCK_OUTPUT_DIVIDER, RG_BAUD_FRACTION_DIVIDER,
      RG_BAUD_FRACTION_MULTIPLIER, RG_TRACE_BUFFER_COMMAND,
      RG_POWERON_PIN_CAPTURE,
      RG_GLITCH_CLOCK_DIV_6, RG_GLITCH_CLOCK_DIV_5, RG_GLITCH_CLOCK_DIV_4,
      RG_GLITCH_CLOCK_DIV_3, RG_GLITCH_CLOCK_DIV_2, RG_GLITCH_CLOCK_DIV_1,
      RG_GLITCH_CLOCK_DIV_0,
      RG_BROWNOUT_CONTROL, RG_TICK_CALIBRATION, RG_IRQ_DELAY_CONTROL,
      RG_NONMASKABLE_SOURCE,
      RG_PIN_IRQ_ROUTE_0, RG_PIN_IRQ_ROUTE_1, RG_PIN_IRQ_ROUTE_2,
      RG_PIN_IRQ_ROUTE_3, RG_PIN_IRQ_ROUTE_4, RG_PIN_IRQ_ROUTE_5,
      RG_PIN_IRQ_ROUTE_6, RG_PIN_IRQ_ROUTE_7,
      RG_PIN_WAKE_ENABLE, RG_IRQ_WAKE_ENABLE,
      RG_DEEPSLEEP_POWER_CONFIG, RG_WAKEUP_POWER_CONFIG,
      RG_RUN_POWER_CONFIG, RG_PART_IDENTIFIER
   } scu_reg_t;

   // ---------------------------------------------------------------
   // byte offsets, indexed by scu_reg_t
   // ---------------------------------------------------------------
   localparam logic [11:0] ROFF [NREG] = '{
      12'h000, 12'h004, 12'h008, 12'h00C, 12'h020, 12'h024, 12'h030,
      12'h040, 12'h044, 12'h070, 12'h074, 12'h078, 12'h080, 12'h094,
      12'h0E0, 12'h0E4, 12'h0E8, 12'h0F0, 12'h0F4, 12'h0FC, 12'h100,
      12'h134, 12'h138, 12'h13C, 12'h140, 12'h144, 12'h148, 12'h14C,
      12'h150, 12'h154, 12'h170, 12'h174,
      12'h178, 12'h17C, 12'h180, 12'h184, 12'h188, 12'h18C, 12'h190,
      12'h194, 12'h204, 12'h214, 12'h230, 12'h234, 12'h238, 12'h3F4
   };

   // ---------------------------------------------------------------
   // values after reset; every register not named here resets to zero
   // ---------------------------------------------------------------
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   localparam logic [31:0] RST_MEMORY_REMAP = 32'h0000_0002;
   localparam logic [31:0] RST_PERIPHERAL_RESET = 32'h0000_1FFF;
   localparam logic [31:0] RST_WDOG_OSC = 32'h0000_00A0;
   localparam logic [31:0] RST_SYSTEM_CLOCK_DIV = 32'h0000_0001;
   localparam logic [31:0] RST_SYSTEM_CLOCK_GATES = 32'h0000_001F;
   localparam logic [31:0] RST_IRQ_DELAY = 32'h0000_0010;
   localparam logic [31:0] RST_DEEPSLEEP_POWER = 32'h0000_FFFF;
   localparam logic [31:0] RST_WAKEUP_POWER = 32'h0000_EDF0;
   localparam logic [31:0] RST_RUN_POWER = 32'h0000_EDF0;

   localparam int NPERIPH = 13;
   localparam int NROUTE = 8;
   localparam int NGLITCH = 7;
   localparam int NCAUSE = 5;

   // ---------------------------------------------------------------
   // configuration handed to the rest of the chip
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [1:0] mem_map;
      logic [NPERIPH-1:0] periph_rst_n;
      logic [1:0] main_clk_sel;
      logic main_clk_upd;
      logic [7:0] baud_div;
      logic [7:0] baud_mul;
      logic [NGLITCH-1:0][7:0] glitch_div;
      logic [7:0] irq_delay;
      logic [NROUTE-1:0][7:0] pin_route;
      logic [31:0] pin_wake_en;
      logic [15:0] sleep_pd;
      logic [15:0] wake_pd;
      logic [15:0] run_pd;
   } scu_cfg_t;

   // all state of the bank
   typedef struct packed {
      logic [NREG-1:0][31:0] regs;
      logic wr_pend;
      logic wr_hit;
      logic [IDX_W-1:0] wr_idx;
      logic [31:0] rdata;
      logic cap_done;
   } scu_state_t;

endpackage

/* verif/scu_cpu_model.sv */
// bus master model standing in for the processor core
`timescale 1ns/100ps
`default_nettype none

module scu_cpu_model (
   input wire logic CLK,
   input wire logic HREADY,
   input wire logic [31:0] HRDATA,
   output logic HSEL,
   output logic [31:0] HADDR,
   output logic [1:0] HTRANS,
   output logic HWRITE,
   output logic [2:0] HSIZE,
   output logic [31:0] HWDATA
);
   initial begin
      HSEL = 1'b0;
      HADDR = 32'h0;
      HTRANS = 2'h0;
      HWRITE = 1'b0;
      HSIZE = 3'h2;
      HWDATA = 32'h0;
   end

   // one whole-word transfer; the caller enters just after a rising edge
   task automatic xfer(input logic wr, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      HSEL <= 1'b1;
      HTRANS <= 2'h2;
      HWRITE <= wr;
      HADDR <= a;
      do @(posedge CLK); while (HREADY !== 1'b1);
      HTRANS <= 2'h0;
      // a read leaves the data lines toggling, never stale
      HWDATA <= wr ? d : ~HWDATA;
      do @(posedge CLK); while (HREADY !== 1'b1);
      q = HRDATA;
   endtask
endmodule // scu_cpu_model

`default_nettype wire

/* verif/scu_regbank_bench.sv */
// self-checking testbench of the config register bank
`timescale 1ns/100ps
`default_nettype none

module scu_regbank_bench;
   import scu_pkg::*;
   // arbitrary identification value, not tied to any part
   localparam logic [31:0] ID_VAL = 32'hA5A5_0003;
   localparam logic [11:0] HOLES [8] = '{12'h010, 12'h014, 12'h028,
      12'h098, 12'h0A0, 12'h104, 12'h168, 12'h3FC};
   logic CLK = 1'b0;
   logic RSTN = 1'b0;
   logic PLL_LOCKED = 1'b0;
   logic [NCAUSE-1:0] RESET_CAUSE = '0;
   logic [31:0] PIN_LEVELS = 32'h0;
   logic HSEL, HWRITE, HREADYOUT, HRESP;
   logic [31:0] HADDR, HWDATA, HRDATA, cap, cause, q;
   logic [1:0] HTRANS, lo;
   logic [2:0] HSIZE;
   scu_cfg_t CFG;
   logic [31:0] m [NREG];
   int mismatches = 0;
   int n_compared = 0;

   always #10 CLK = ~CLK;

   scu_regbank #(.PART_ID(ID_VAL)) u_dut (.CLK(CLK), .RSTN(RSTN),
      .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
      .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
      .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP),
      .PLL_LOCKED(PLL_LOCKED), .RESET_CAUSE(RESET_CAUSE),
      .PIN_LEVELS(PIN_LEVELS), .CFG(CFG));
   scu_cpu_model u_cpu (.CLK(CLK), .HREADY(HREADYOUT), .HRDATA(HRDATA),
      .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
      .HSIZE(HSIZE), .HWDATA(HWDATA));

   // ----------------------------------------
   // expectations
   // ----------------------------------------
   function automatic logic [31:0] rst_val(int i);
      case (i)
         RG_MEMORY_REMAP: return RST_MEMORY_REMAP;
         RG_PERIPHERAL_RESET_CONTROL: return RST_PERIPHERAL_RESET;
         RG_WDOG_OSC_CONTROL: return RST_WDOG_OSC;
         RG_SYSTEM_CLOCK_DIVIDER: return RST_SYSTEM_CLOCK_DIV;
         RG_SYSTEM_CLOCK_GATES: return RST_SYSTEM_CLOCK_GATES;
         RG_IRQ_DELAY_CONTROL: return RST_IRQ_DELAY;
         RG_DEEPSLEEP_POWER_CONFIG: return RST_DEEPSLEEP_POWER;
         RG_WAKEUP_POWER_CONFIG: return RST_WAKEUP_POWER;
         RG_RUN_POWER_CONFIG: return RST_RUN_POWER;
         default: return RST_ZERO;
      endcase
   endfunction

   function automatic logic [31:0] exp_rd(int i);
      case (i)
         RG_PLL_STATUS: return {31'h0, PLL_LOCKED};
         RG_RESET_CAUSE_STATUS: return cause;
         RG_POWERON_PIN_CAPTURE: return cap;
         RG_PART_IDENTIFIER: return ID_VAL;
         default: return m[i];
      endcase
   endfunction

   function automatic scu_cfg_t exp_cfg();
      scu_cfg_t c;
      c.mem_map = m[RG_MEMORY_REMAP][1:0];
      c.periph_rst_n = m[RG_PERIPHERAL_RESET_CONTROL][NPERIPH-1:0];
      c.main_clk_sel = m[RG_MAIN_CLOCK_SELECT][1:0];
      c.main_clk_upd = m[RG_MAIN_CLOCK_UPDATE][0];
      c.baud_div = m[RG_BAUD_FRACTION_DIVIDER][7:0];
      c.baud_mul = m[RG_BAUD_FRACTION_MULTIPLIER][7:0];
      for (int k = 0; k < NGLITCH; k++)
         c.glitch_div[k] = m[RG_GLITCH_CLOCK_DIV_0 - k][7:0];
      c.irq_delay = m[RG_IRQ_DELAY_CONTROL][7:0];
      for (int k = 0; k < NROUTE; k++)
         c.pin_route[k] = m[RG_PIN_IRQ_ROUTE_0 + k][7:0];
      c.pin_wake_en = m[RG_PIN_WAKE_ENABLE];
      c.sleep_pd = m[RG_DEEPSLEEP_POWER_CONFIG][15:0];
      c.wake_pd = m[RG_WAKEUP_POWER_CONFIG][15:0];
      c.run_pd = m[RG_RUN_POWER_CONFIG][15:0];
      return c;
   endfunction

   // ----------------------------------------
   // compares, bus access, reset, verdict
   // ----------------------------------------
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: read %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_cfg(input scu_cfg_t got, input scu_cfg_t exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: config %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input int i, input logic [31:0] d);
      logic [31:0] r;
      u_cpu.xfer(1'b1, {20'h0, ROFF[i]} | {30'h0, lo}, d, r);
      if (i == RG_RESET_CAUSE_STATUS)
         cause = cause & ~d;
      else if (!(i inside {RG_PLL_STATUS, RG_POWERON_PIN_CAPTURE,
                           RG_PART_IDENTIFIER}))
         m[i] = d;
   endtask

   task automatic chk(input int i);
      logic [31:0] r;
      u_cpu.xfer(1'b0, {20'h0, ROFF[i]} | {30'h0, lo}, 32'h0, r);
      cmp_word(r, exp_rd(i));
      cmp_word({31'h0, HRESP}, 32'h0);
   endtask

   task automatic do_reset();
      RSTN <= 1'b0;
      PIN_LEVELS <= $urandom();
      repeat (4) @(posedge CLK);
      RSTN <= 1'b1;
      repeat (4) @(posedge CLK);
      cap = PIN_LEVELS;
      cause = 32'h0;
      foreach (m[i]) m[i] = rst_val(i);
      // later pin changes must not reach the capture
      PIN_LEVELS <= ~cap;
   endtask

   task automatic complete_run();
      if (mismatches == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      #500000;
      mismatches++;
      complete_run();
   end

   initial begin
      int k;
      void'($urandom(91));
      lo = 2'h0;
      do_reset();
      for (int i = 0; i < NREG; i++)
         chk(i);
      cmp_cfg(CFG, exp_cfg());
      PLL_LOCKED <= 1'b1;
      // all-zero then all-one words, back to back with their reads
      for (int i = 0; i < NREG; i++)
         for (int b = 0; b < 2; b++) begin
            wr(i, {32{b[0]}});
            chk(i);
            cmp_cfg(CFG, exp_cfg());
         end
      repeat (80) begin
         k = $urandom_range(NREG - 1);
         wr(k, $urandom());
         chk(k);
         cmp_cfg(CFG, exp_cfg());
      end
      lo = 2'h3;
      repeat (20) begin
         k = $urandom_range(NREG - 1);
         wr(k, $urandom());
         chk(k);
      end
      lo = 2'h0;
      // deliberate writes to reserved offsets, made only here
      foreach (HOLES[h]) begin
         u_cpu.xfer(1'b1, {20'h0, HOLES[h]}, $urandom(), q);
         u_cpu.xfer(1'b0, {20'h0, HOLES[h]}, 32'h0, q);
         cmp_word(q, 32'h0);
      end
      wr(RG_POWERON_PIN_CAPTURE, ~cap);
      wr(RG_PART_IDENTIFIER, ~ID_VAL);
      for (int i = 0; i < NREG; i++)
         chk(i);
      RESET_CAUSE <= 5'h15;
      @(posedge CLK);
      RESET_CAUSE <= 5'h00;
      cause = cause | 32'h15;
      @(posedge CLK);
      chk(RG_RESET_CAUSE_STATUS);
      wr(RG_RESET_CAUSE_STATUS, 32'h11);
      chk(RG_RESET_CAUSE_STATUS);
      do_reset();
      for (int i = 0; i < NREG; i++)
         chk(i);
      cmp_cfg(CFG, exp_cfg());
      complete_run();
   end
endmodule // scu_regbank_bench

`default_nettype wire
